//--- rtl/meot_top.sv
// Motion event output trigger top: two channels driving four outputs
`timescale 1ns/100ps
module meot_top import meot_pkg::*; #(
	parameter int MS_DIV = MS_CYCLES
) (
	// Clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  nrst_in,
	// Event channel commands: cfg_in and clr_in one bit per channel, the other fields shared by both channels
	input  wire logic [CHANNELS-1:0]   cfg_in,
	input  wire logic [CHANNELS-1:0]   clr_in,
	input  wire logic [SEL_W-1:0]      sel_in,
	input  wire logic                  level_in,
	input  wire logic [1:0]            src_in,
	input  wire logic [VAL_W-1:0]      value_in,
	// Motion status from the profile generator
	input  wire logic                  start_in,
	input  wire logic                  moving_in,
	input  wire logic                  step_in,
	input  wire logic [VAL_W-1:0]      speed_in,
	// General output control
	input  wire logic [OUTPUTS-1:0]    sys_assign_in,
	input  wire logic [OUTPUTS-1:0]    out_wr_in,
	input  wire logic [OUTPUTS-1:0]    out_wr_val_in,
	// Outputs and status
	output logic [OUTPUTS-1:0]         gen_out,
	output logic [CHANNELS-1:0]        armed_out,
	output logic [CHANNELS-1:0]        fired_out
);
	if (MS_DIV < 1) begin : g_bad_div
		$error("meot_top: bad divider");
	end

	// ====================================================================
	// Motion measures, restarted at each start
	logic             tick;
	logic [VAL_W-1:0] ms_cnt;
	logic [VAL_W-1:0] dist_cnt;
	wire ms_max   = (ms_cnt == DIST_MAX);
	wire dist_max = (dist_cnt == DIST_MAX);

	meot_ms_tick #(
		.DIV(MS_DIV)
	) u_tick (
		.core_clk_in(core_clk_in),
		.nrst_in    (nrst_in),
		.restart_in (start_in),
		.run_in     (moving_in),
		.tick_out   (tick)
	);

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ms_cnt   <= '0;
			dist_cnt <= '0;
		end else if (start_in) begin
			ms_cnt   <= '0;
			dist_cnt <= '0;
		end else begin
			if (tick && !ms_max) begin
				ms_cnt <= ms_cnt + 1'b1;
			end
			if (step_in && moving_in && !dist_max) begin
				dist_cnt <= dist_cnt + 1'b1;
			end
		end
	end

	// Zero between motions: a rearmed time or distance channel never fires on a stale move
	wire [VAL_W-1:0] ms_now   = moving_in ? ms_cnt : '0;
	wire [VAL_W-1:0] dist_now = moving_in ? dist_cnt : '0;

	// ====================================================================
	// Channels, each checked on its own
	logic [CHANNELS-1:0] done;
	logic [CHANNELS-1:0] fire;
	logic [CHANNELS-1:0] lvl;
	logic [SEL_W-1:0]    sel [CHANNELS];

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		meot_channel u_ch (
			.core_clk_in(core_clk_in),
			.nrst_in    (nrst_in),
			.cfg_in     (cfg_in[c]),
			.clr_in     (clr_in[c]),
			.sel_in     (sel_in),
			.level_in   (level_in),
			.src_in     (src_in),
			.value_in   (value_in),
			.start_in   (start_in),
			.ms_in      (ms_now),
			.dist_in    (dist_now),
			.speed_in   (speed_in),
			.armed_out  (armed_out[c]),
			.done_out   (done[c]),
			.sel_out    (sel[c]),
			.level_out  (lvl[c]),
			.fire_out   (fire[c])
		);
	end

	// ====================================================================
	// Output update; channel 1 wins a same-cycle clash on one output
	logic [OUTPUTS-1:0] next_out;
	always_comb begin
		next_out = gen_out;
		for (int o = 0; o < OUTPUTS; o++) begin
			if (out_wr_in[o]) begin
				next_out[o] = out_wr_val_in[o];
			end
			for (int c = 0; c < CHANNELS; c++) begin
				if (fire[c] && (sel[c] == SEL_W'(o)) && !sys_assign_in[o]) begin
					next_out[o] = lvl[c];
				end
			end
		end
	end

	// Clearing a channel never touches gen_out
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			gen_out   <= OUT_RESET;
			fired_out <= '0;
		end else begin
			gen_out   <= next_out;
			fired_out <= done & armed_out;
		end
	end
endmodule // meot_top

//--- pkg/meot_pkg.sv
// Constants for the motion event output trigger block
package meot_pkg;
	// ====================================================================
	// Sizes
	localparam int CHANNELS      = 2;
	localparam int OUTPUTS       = 4;
	localparam int SEL_W         = 2;
	localparam int VAL_W         = 23;
	localparam int CLK_HZ        = 20000000;
	localparam int TICK_MS       = 1;
	localparam int MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_CNT_W      = 15;
	localparam logic [VAL_W-1:0] TIME_MAX_MS  = 23'h07a120;
	localparam logic [VAL_W-1:0] DIST_MAX     = 23'h7fffff;
	localparam logic [VAL_W-1:0] SPEED_MAX    = 23'h07a120;
	localparam logic [VAL_W-1:0] SPEED_MIN    = 23'h000001;
	localparam logic [OUTPUTS-1:0] OUT_RESET  = 4'h0;

	// ====================================================================
	// Trigger sources
	typedef enum logic [1:0] {
		MEOT_SRC_TIME  = 2'b00,
		MEOT_SRC_DIST  = 2'b01,
		MEOT_SRC_SPEED = 2'b10
	} meot_src_t;
endpackage

//--- rtl/meot_ms_tick.sv
// Millisecond tick divider restarted at motion start
`timescale 1ns/100ps
module meot_ms_tick import meot_pkg::*; #(
	parameter int DIV = MS_CYCLES
) (
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic nrst_in,
	// Control
	input  wire logic restart_in,
	input  wire logic run_in,
	output logic      tick_out
);
	// Counter width bounds the divider
	if (DIV < 1 || DIV > (2 ** MS_CNT_W) - 1) begin : g_bad_div
		$error("meot_ms_tick: bad divider");
	end
	logic [MS_CNT_W-1:0] cnt;
	wire  last = (cnt == MS_CNT_W'(DIV - 1));
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt      <= '0;
			tick_out <= 1'b0;
		end else if (restart_in || !run_in) begin
			cnt      <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt      <= last ? '0 : cnt + 1'b1;
			tick_out <= last;
		end
	end
endmodule // meot_ms_tick

//--- rtl/meot_channel.sv
// One event channel: arming, trigger check and one-shot fire
`timescale 1ns/100ps
module meot_channel import meot_pkg::*; (
	// Clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             nrst_in,
	// Command
	input  wire logic             cfg_in,
	input  wire logic             clr_in,
	input  wire logic [SEL_W-1:0] sel_in,
	input  wire logic             level_in,
	input  wire logic [1:0]       src_in,
	input  wire logic [VAL_W-1:0] value_in,
	// Motion
	input  wire logic             start_in,
	input  wire logic [VAL_W-1:0] ms_in,
	input  wire logic [VAL_W-1:0] dist_in,
	input  wire logic [VAL_W-1:0] speed_in,
	// State
	output logic                  armed_out,
	output logic                  done_out,
	output logic [SEL_W-1:0]      sel_out,
	output logic                  level_out,
	output logic                  fire_out
);
	logic [1:0]       src;
	logic [VAL_W-1:0] value;
	wire hit_time  = (src == MEOT_SRC_TIME)  && (ms_in >= value);
	wire hit_dist  = (src == MEOT_SRC_DIST)  && (dist_in >= value);
	wire hit_speed = (src == MEOT_SRC_SPEED) && (speed_in >= value);
	wire hit       = hit_time || hit_dist || hit_speed;
	wire next_fire = armed_out && !done_out && !start_in && !cfg_in && hit;
	// Out-of-range values are clamped rather than refused
	wire [VAL_W-1:0] cap = (src_in == MEOT_SRC_TIME) ? TIME_MAX_MS :
	                       (src_in == MEOT_SRC_DIST) ? DIST_MAX : SPEED_MAX;
	wire [VAL_W-1:0] next_value = (value_in > cap) ? cap :
	                 ((src_in == MEOT_SRC_SPEED) && (value_in < SPEED_MIN)) ? SPEED_MIN
	                 : value_in;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			armed_out <= 1'b0;
			done_out  <= 1'b0;
			sel_out   <= '0;
			level_out <= 1'b0;
			src       <= MEOT_SRC_TIME;
			value     <= '0;
			fire_out  <= 1'b0;
		end else begin
			fire_out <= next_fire;
			if (clr_in) begin
				armed_out <= 1'b0;
			end else if (cfg_in) begin
				armed_out <= 1'b1;
				done_out  <= 1'b0;
				sel_out   <= sel_in;
				level_out <= level_in;
				src       <= (src_in == 2'b11) ? MEOT_SRC_SPEED : src_in;
				value     <= next_value;
			end else if (start_in) begin
				done_out <= 1'b0;
			end else if (next_fire) begin
				done_out <= 1'b1;
			end
		end
	end
endmodule // meot_channel

//--- verif/meot_motion_model.sv
// Motion profile model: start pulse, steps and speed ramp
`timescale 1ns/100ps
module meot_motion_model import meot_pkg::*; (
	// Clock, command and motion
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        run_in,
	output logic             start_out,
	output logic             moving_out,
	output logic             step_out,
	output logic [VAL_W-1:0] speed_out
);
	// One step every other cycle keeps the travel count easy to predict
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{start_out, moving_out, step_out, speed_out} <= '0;
		end else begin
			start_out <= run_in & ~moving_out;
			moving_out <= run_in;
			step_out <= run_in & moving_out & ~step_out;
			speed_out <= run_in ? speed_out + 23'h000001 : '0;
		end
	end
endmodule // meot_motion_model

//--- verif/meot_top_asserts.sv
// Port checks for the event trigger top
`timescale 1ns/100ps
module meot_top_asserts import meot_pkg::*; (
	// Watched ports
	input wire logic                core_clk_in,
	input wire logic                nrst_in,
	input wire logic [CHANNELS-1:0] cfg_in,
	input wire logic [CHANNELS-1:0] clr_in,
	input wire logic                start_in,
	input wire logic [OUTPUTS-1:0]  sys_assign_in,
	input wire logic [OUTPUTS-1:0]  out_wr_in,
	input wire logic [OUTPUTS-1:0]  gen_out,
	input wire logic [CHANNELS-1:0] armed_out,
	input wire logic [CHANNELS-1:0] fired_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	a_cfg_arms: assert property (cfg_in[0] && !clr_in[0] |=> armed_out[0])
		else $error("channel not armed");
	a_clr_disarms: assert property (clr_in[1] |=> !armed_out[1])
		else $error("channel not disarmed");
	a_armed_holds: assert property (armed_out[0] && !clr_in[0] |=> armed_out[0])
		else $error("arming lost");
	a_sys_blocks: assert property (
		sys_assign_in[0] && $past(sys_assign_in[0]) && !out_wr_in[0] |=> $stable(gen_out[0]))
		else $error("system output changed");
	a_fire_once: assert property (
		fired_out[0] && !start_in && !$past(start_in) && !cfg_in[0] && !$past(cfg_in[0])
		&& !clr_in[0] && !$past(clr_in[0]) |=> fired_out[0])
		else $error("fired flag dropped");
	a_fire_armed: assert property ($rose(fired_out[1]) |-> $past(armed_out[1]))
		else $error("fire while disarmed");
	a_gen_cause: assert property (
		$changed(gen_out) && $past(out_wr_in) == '0
		|-> (fired_out & ~$past(fired_out)) != '0)
		else $error("output changed without cause");
	a_idle_still: assert property (
		armed_out == '0 && $past(armed_out) == '0
		&& $past(armed_out, 2) == '0 && out_wr_in == '0 |=> $stable(gen_out))
		else $error("output moved while idle");
endmodule // meot_top_asserts
bind meot_top meot_top_asserts meot_top_asserts_inst (.*);

//--- verif/meot_top_test.sv
// Self-checking bench for the event trigger top
`timescale 1ns/100ps
module meot_top_test;
	import meot_pkg::*;
	logic             clk = 0, nrst = 0, run = 0, lvl = 0, st, mv, stp;
	logic [1:0]       cfg = '0, clr = '0, src = '0, sel = '0, armed, fired;
	logic [VAL_W-1:0] val = '0, spd;
	logic [3:0]       sys = '0, wr = '0, wv = '0, gen;
	int               num_errors = 0, num_checks = 0;
	meot_motion_model meot_motion_model_inst (.clk_in(clk), .nrst_in(nrst), .run_in(run),
		.start_out(st), .moving_out(mv), .step_out(stp), .speed_out(spd));
	// Short millisecond divider keeps the run brief
	meot_top #(.MS_DIV(4)) meot_top_inst (.core_clk_in(clk), .nrst_in(nrst), .cfg_in(cfg),
		.clr_in(clr), .sel_in(sel), .level_in(lvl), .src_in(src), .value_in(val),
		.start_in(st), .moving_in(mv), .step_in(stp), .speed_in(spd), .sys_assign_in(sys),
		.out_wr_in(wr), .out_wr_val_in(wv), .gen_out(gen), .armed_out(armed), .fired_out(fired));
	initial forever #25 clk = ~clk;
	// ====================
	// Tasks
	task automatic chk(input string what, input logic [3:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		// Ends mid-cycle, so outputs read afterwards have settled
		repeat (n) @(negedge clk);
	endtask
	task automatic arm(input int ch, input logic [1:0] o, input logic l, input logic [1:0] s,
		input logic [VAL_W-1:0] v);
		@(posedge clk);
		{cfg, sel, lvl, src, val} <= {2'b01 << ch, o, l, s, v};
		@(posedge clk);
		cfg <= '0;
	endtask
	task automatic drop(input int ch);
		@(posedge clk);
		clr <= 2'b01 << ch;
		@(posedge clk);
		clr <= '0;
	endtask
	task automatic put(input logic [3:0] m, v);
		@(posedge clk);
		{wr, wv} <= {m, v};
		@(posedge clk);
		wr <= '0;
	endtask
	task automatic go(input logic r);
		@(posedge clk);
		run <= r;
		tick(3);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ====================
	// Sequence
	initial begin
		tick(2000);
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		put(4'hf, 4'h0);
		arm(0, 2'd1, 1'b1, 2'd2, 23'h00000a);
		arm(1, 2'd0, 1'b1, 2'd0, 23'h000002);
		tick(1);
		chk("armed", armed, 4'h3);
		go(1'b1);
		tick(3);
		chk("gen early", gen, 4'h0);
		tick(14);
		chk("gen fired", gen, 4'h3);
		chk("fired", fired, 4'h3);
		put(4'h2, 4'h0);
		tick(4);
		chk("gen once", gen, 4'h1);
		go(1'b0);
		go(1'b1);
		tick(17);
		chk("gen rearm", gen, 4'h3);
		go(1'b0);
		arm(0, 2'd2, 1'b1, 2'd1, 23'h000005);
		go(1'b1);
		tick(3);
		chk("dist early", gen, 4'h3);
		tick(14);
		chk("dist fired", gen, 4'h7);
		drop(0);
		tick(2);
		chk("armed clr", armed, 4'h2);
		chk("gen clr", gen, 4'h7);
		go(1'b0);
		put(4'h4, 4'h0);
		go(1'b1);
		tick(17);
		chk("gen disarmed", gen, 4'h3);
		go(1'b0);
		arm(1, 2'd0, 1'b0, 2'd0, 23'h000000);
		sys <= 4'h1;
		go(1'b1);
		tick(10);
		chk("gen sys", gen, 4'h3);
		go(1'b0);
		@(posedge clk) sys <= '0;
		go(1'b1);
		tick(10);
		chk("gen low", gen, 4'h2);
		drop(1);
		tick(2);
		chk("armed clr2", armed, 4'h0);
		chk("gen clr2", gen, 4'h2);
		complete_run();
	end
endmodule // meot_top_test
